// ### hdl/nvc_regs.svh
// nvm controller constants: register offsets, field positions, command codes, timing
// assumes inclusion by the design and simulation files by bare name
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

// ----------------------------------------
// register offsets (byte index on the register port)
// ----------------------------------------
`define NVC_ADDR0      4'h0
`define NVC_ADDR1      4'h1
`define NVC_DATA0      4'h2
`define NVC_DATA1      4'h3
`define NVC_CMD        4'h4
`define NVC_NVM_CONTROL_A      4'h5
`define NVC_CTRLB      4'h6
`define NVC_STATUS     4'h7
`define NVC_PROTECT    4'h8

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define NVC_NVM_CONTROL_A_EXEC 0
`define NVC_STAT_BUSY  7
`define NVC_STAT_FAIL  6
`define NVC_STAT_FLOAD 1
`define NVC_STAT_ELOAD 0
`define NVC_UNLOCK_KEY 8'h9d
`define NVC_UNLOCK_WIN 3'h4
`define NVC_CMD_RESET  7'h00
`define NVC_FLASH_ONES 16'hffff
`define NVC_EE_ONES    8'hff

// ----------------------------------------
// command codes
// ----------------------------------------
`define NVC_C_NOP      7'h00
`define NVC_C_LD_FBUF  7'h23
`define NVC_C_ER_FBUF  7'h26
`define NVC_C_ER_FPG   7'h2b
`define NVC_C_WR_FPG   7'h2e
`define NVC_C_EW_FPG   7'h2f
`define NVC_C_CRC      7'h3a
`define NVC_C_LD_EBUF  7'h33
`define NVC_C_ER_EBUF  7'h36
`define NVC_C_ER_EPG   7'h32
`define NVC_C_WR_EPG   7'h34
`define NVC_C_EW_EPG   7'h35
`define NVC_C_WR_SIG   7'h01
`define NVC_C_WR_LOCK  7'h08
`define NVC_C_WR_FUSE  7'h4c
`define NVC_C_RD_PSIG  7'h02

// ----------------------------------------
// timing: operation time in ns, cycles at 10 MHz
// ----------------------------------------
`define NVC_CLK_NS     100
`define NVC_OP_NS      2000
`define NVC_OP_CYC     (`NVC_OP_NS / `NVC_CLK_NS)

`endif

// ### hdl/nvc_pkg.sv
// nvm controller types
// assumes the constants header beside it
package nvc_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		NVC_IDLE,
		NVC_RUN,
		NVC_CLEAR
	} nvc_state_t;

	// which page buffer an operation clears on completion
	typedef struct packed {
		logic flash;
		logic ee;
	} nvc_clr_t;
endpackage

// ### hdl/nvc_buf_if.sv
// page buffer port bundle between sequencer and buffer modules
// assumes one clock shared with both ends
interface nvc_buf_if;
	logic        load;   // load pulse
	logic        clear;  // clear pulse
	logic [3:0]  index;  // location
	logic [15:0] wdata;  // value to and in
	logic [15:0] rdata;  // location content
	logic        tag;    // location tagged (ee)
	logic        any;    // any location loaded

	modport ctrl (output load, clear, index, wdata, input rdata, tag, any);
	modport buff (input load, clear, index, wdata, output rdata, tag, any);
endinterface

// ### hdl/nvc_flash_buf.sv
// flash page buffer: 16 words, anded load, all ones when cleared
// assumes one load or clear at a time from the sequencer
module nvc_flash_buf
	import nvc_pkg::*;
(
	input  wire logic clock_i,  // system clock
	input  wire logic rst_n_i,  // sync reset, active low
	nvc_buf_if.buff   bus       // buffer port
);
`include "nvc_regs.svh"

	typedef struct packed {
		logic [15:0][15:0] mem;
		logic             any;
	} nvc_fb_t;

	nvc_fb_t st, next_st;

	// ----------------------------------------
	// load and clear
	// ----------------------------------------
	always_comb begin
		next_st = st;
		if (bus.clear) begin
			next_st.mem = {16{`NVC_FLASH_ONES}};  // RULE_11
			next_st.any = 1'b0;
		end else if (bus.load) begin
			next_st.mem[bus.index] = st.mem[bus.index] & bus.wdata;  // RULE_10
			next_st.any = 1'b1;
		end
	end

	// register state; reset empties the buffer
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st <= '{mem: {16{16'hffff}}, any: 1'b0};  // RULE_12
		end else begin
			st <= next_st;
		end
	end

	assign bus.rdata = st.mem[bus.index];
	assign bus.tag   = 1'b0;
	assign bus.any   = st.any;
endmodule // nvc_flash_buf

// ### hdl/nvc_ee_buf.sv
// eeprom page buffer: 16 bytes with per-location tags
// assumes one load or clear at a time from the sequencer
module nvc_ee_buf
	import nvc_pkg::*;
(
	input  wire logic clock_i,  // system clock
	input  wire logic rst_n_i,  // sync reset, active low
	nvc_buf_if.buff   bus       // buffer port
);
`include "nvc_regs.svh"

	typedef struct packed {
		logic [15:0][7:0] mem;
		logic [15:0]      tags;
	} nvc_eb_t;

	nvc_eb_t st, next_st;

	// ----------------------------------------
	// load tags the location and ands the byte
	// ----------------------------------------
	always_comb begin
		next_st = st;
		if (bus.clear) begin
			next_st.mem  = {16{`NVC_EE_ONES}};
			next_st.tags = 16'h0000;  // RULE_16
		end else if (bus.load) begin
			next_st.mem[bus.index]  = st.mem[bus.index] & bus.wdata[7:0];  // RULE_10
			next_st.tags[bus.index] = 1'b1;  // RULE_14
		end
	end

	// register state; reset empties buffer and tags
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st <= '{mem: {16{8'hff}}, tags: 16'h0000};  // RULE_16
		end else begin
			st <= next_st;
		end
	end

	assign bus.rdata = {8'h00, st.mem[bus.index]};
	assign bus.tag   = st.tags[bus.index];
	assign bus.any   = |st.tags;
endmodule // nvc_ee_buf

// ### hdl/nvc_ctrl.sv
// nvm command sequencer with register port and two page buffers
// assumes strobes synchronous to clock_i and a memory array outside answering mem_done_i
//
// How it works
// [RULE_01] command, address, data set in registers
// [RULE_02] ctrl a execute bit starts action commands
// [RULE_03] memory read or write starts matching commands
// [RULE_04] self-programming triggers need unlock sequence first
// [RULE_05] busy flag blocks controller register writes
// [RULE_06] initiator never addresses memory while busy
// [RULE_07] programming blocks other programming, loads, reads; code blocks only external and application-section reads while busy
// [RULE_08] software masks interrupts during self-programming
// [RULE_09] flash buffer word loads, erase first
// [RULE_10] loading ands new value into location
// [RULE_11] unloaded flash locations read all ones
// [RULE_12] flash buffer cleared on reset, writes
// [RULE_13] eeprom buffer byte loads, erase first
// [RULE_14] only tagged eeprom locations get programmed
// [RULE_15] initiator loads locations to tag erase
// [RULE_16] eeprom buffer, tags cleared reset, writes
// [RULE_17] flash page erased before page write
// [RULE_18] split erase and write share page
// [RULE_19] eeprom buffer filled before erase, write
// [RULE_20] production signature row read only externally
// [RULE_21] processor stalled until flash operation ends
// [RULE_22] brownout aborts programming at once
// [RULE_23] busy clears at end, writes accepted next
module nvc_ctrl
	import nvc_pkg::*;
(
	input  wire logic        clock_i,      // system clock, 10 MHz
	input  wire logic        rst_n_i,      // sync reset, active low
	input  wire logic [3:0]  reg_addr_i,   // register address
	input  wire logic [7:0]  reg_wdata_i,  // register write data
	input  wire logic        reg_wr_i,     // register write strobe
	input  wire logic        reg_rd_i,     // register read strobe
	output logic      [7:0]  reg_rdata_o,  // register read data, next cycle
	input  wire logic        external_i,   // access from program_debug_port
	input  wire logic        mem_rd_i,     // memory read trigger
	input  wire logic        mem_wr_i,     // memory write trigger
	input  wire logic        app_rd_i,     // read is from application section
	input  wire logic        brownout_i,   // brownout_monitor threshold hit
	input  wire logic        mem_done_i,   // array finished operation
	output logic             mem_start_o,  // start pulse to array
	output logic      [6:0]  mem_cmd_o,    // command to array
	output logic      [15:0] mem_addr_o,   // latched address to array
	output logic      [15:0] mem_wdata_o,  // buffer word for address
	output logic             mem_tag_o,    // eeprom location tagged
	output logic             rd_grant_o,   // memory read allowed
	output logic             cpu_stall_o,  // processor halt
	output logic             busy_o        // operation in progress
);
`include "nvc_regs.svh"

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		nvc_state_t  fsm;
		logic [15:0] addr;
		logic [15:0] data;
		logic [6:0]  cmd;
		logic [7:0]  ctrlb;
		logic [2:0]  unlock;
		logic        fail;
		logic [4:0]  timer;
		nvc_clr_t    clr;
		logic [6:0]  run_cmd;
		logic [7:0]  rdata;
		logic        start;
		logic        grant;
		logic        stall;
		logic [15:0] wout;
		logic        tout;
		logic        busy_flag;
	} nvc_st_t;

	nvc_st_t st, next_st;

	nvc_buf_if fbuf();
	nvc_buf_if ebuf();

	nvc_flash_buf u_flash_buf (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.bus     (fbuf.buff)
	);

	nvc_ee_buf u_ee_buf (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.bus     (ebuf.buff)
	);

	// long commands occupy the array and raise busy
	function automatic logic is_prog(input logic [6:0] c);
		is_prog = (c == `NVC_C_ER_FPG) || (c == `NVC_C_WR_FPG) || (c == `NVC_C_EW_FPG)
			|| (c == `NVC_C_ER_EPG) || (c == `NVC_C_WR_EPG) || (c == `NVC_C_EW_EPG)
			|| (c == `NVC_C_WR_SIG) || (c == `NVC_C_WR_LOCK) || (c == `NVC_C_WR_FUSE)
			|| (c == `NVC_C_CRC);
	endfunction

	// action class commands
	function automatic logic is_action(input logic [6:0] c);
		is_action = (c == `NVC_C_ER_FBUF) || (c == `NVC_C_ER_EBUF) || (c == `NVC_C_CRC);
	endfunction

	// flash buffer cleared on completion of these
	function automatic logic clr_flash(input logic [6:0] c);
		clr_flash = (c == `NVC_C_WR_FPG) || (c == `NVC_C_EW_FPG)
			|| (c == `NVC_C_WR_SIG) || (c == `NVC_C_WR_LOCK);
	endfunction

	// eeprom buffer cleared on completion of these
	function automatic logic clr_ee(input logic [6:0] c);
		clr_ee = (c == `NVC_C_WR_EPG) || (c == `NVC_C_EW_EPG)
			|| (c == `NVC_C_WR_LOCK) || (c == `NVC_C_WR_FUSE);
	endfunction

	logic busy;
	logic unlocked;
	logic act_trig;
	logic wr_trig;
	logic rd_trig;
	logic launch;
	logic [6:0] launch_cmd;

	// ----------------------------------------
	// trigger decode
	// ----------------------------------------
	always_comb begin
		busy     = (st.fsm != NVC_IDLE);
		unlocked = external_i || (st.unlock != 3'h0);  // RULE_04
		act_trig = reg_wr_i && (reg_addr_i == `NVC_NVM_CONTROL_A) && !busy
			&& reg_wdata_i[`NVC_NVM_CONTROL_A_EXEC] && is_action(st.cmd) && unlocked;  // RULE_02 RULE_04
		wr_trig  = mem_wr_i && !busy && (st.cmd != `NVC_C_NOP)
			&& (unlocked || st.cmd == `NVC_C_LD_FBUF || st.cmd == `NVC_C_LD_EBUF)  // RULE_04
			&& !(external_i && st.cmd == `NVC_C_RD_PSIG);  // RULE_20
		rd_trig  = mem_rd_i && !busy;  // RULE_03
		launch     = (act_trig || wr_trig) && is_prog(st.cmd);  // RULE_03
		launch_cmd = st.cmd;
	end

	// ----------------------------------------
	// buffer drive
	// ----------------------------------------
	always_comb begin
		fbuf.index = busy ? st.addr[4:1] : st.addr[4:1];
		ebuf.index = st.addr[3:0];
		fbuf.wdata = st.data;  // RULE_09
		ebuf.wdata = {8'h00, st.data[7:0]};  // RULE_13
		fbuf.load  = wr_trig && (st.cmd == `NVC_C_LD_FBUF);  // RULE_07 RULE_09
		ebuf.load  = wr_trig && (st.cmd == `NVC_C_LD_EBUF);  // RULE_07 RULE_13
		fbuf.clear = (act_trig && st.cmd == `NVC_C_ER_FBUF)
			|| (st.fsm == NVC_CLEAR && st.clr.flash);  // RULE_12
		ebuf.clear = (act_trig && st.cmd == `NVC_C_ER_EBUF)
			|| (st.fsm == NVC_CLEAR && st.clr.ee);  // RULE_16
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st       = st;
		next_st.start = 1'b0;
		next_st.grant = 1'b0;
		next_st.wout  = st.run_cmd[4] ? ebuf.rdata : fbuf.rdata;
		next_st.tout  = ebuf.tag;  // RULE_14
		// unlock window counts down; key write opens it
		if (st.unlock != 3'h0) begin
			next_st.unlock = st.unlock - 3'h1;
		end
		if (reg_wr_i && reg_addr_i == `NVC_PROTECT && reg_wdata_i == `NVC_UNLOCK_KEY) begin
			next_st.unlock = `NVC_UNLOCK_WIN;  // RULE_04
		end
		// register writes only while idle
		if (reg_wr_i && !busy) begin  // RULE_05 RULE_01
			unique case (reg_addr_i)
				`NVC_ADDR0: next_st.addr[7:0]  = reg_wdata_i;
				`NVC_ADDR1: next_st.addr[15:8] = reg_wdata_i;
				`NVC_DATA0: next_st.data[7:0]  = reg_wdata_i;
				`NVC_DATA1: next_st.data[15:8] = reg_wdata_i;
				`NVC_CMD:   next_st.cmd        = reg_wdata_i[6:0];
				`NVC_CTRLB: next_st.ctrlb      = reg_wdata_i;
				`NVC_STATUS: next_st.fail      = st.fail & ~reg_wdata_i[`NVC_STAT_FAIL];
				default: ;
			endcase
		end
		// reads gated while programming; external and app reads blocked
		if (mem_rd_i) begin
			next_st.grant = rd_trig || !(external_i || app_rd_i);  // RULE_07
		end
		// sequencer
		unique case (st.fsm)
			NVC_IDLE: begin
				if (launch) begin
					next_st.fsm     = NVC_RUN;  // RULE_05
					next_st.run_cmd = launch_cmd;
					next_st.start   = 1'b1;
					next_st.timer   = 5'(`NVC_OP_CYC);
					next_st.stall   = !external_i;  // RULE_21
					next_st.clr     = '{flash: clr_flash(launch_cmd), ee: clr_ee(launch_cmd)};
				end
			end
			NVC_RUN: begin
				if (brownout_i) begin
					next_st.fsm   = NVC_IDLE;  // RULE_22
					next_st.fail  = 1'b1;
					next_st.stall = 1'b0;
				end else if (mem_done_i || st.timer == 5'h00) begin
					next_st.fsm = NVC_CLEAR;
				end else begin
					next_st.timer = st.timer - 5'h01;
				end
			end
			NVC_CLEAR: begin
				next_st.fsm   = NVC_IDLE;  // RULE_23
				next_st.stall = 1'b0;  // RULE_21
			end
			default: next_st.fsm = NVC_IDLE;
		endcase
		// busy output kept in its own flop, follows the next state
		next_st.busy_flag = (next_st.fsm != NVC_IDLE);  // RULE_05
		// read data, one cycle after strobe
		next_st.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`NVC_ADDR0:  next_st.rdata = st.addr[7:0];
				`NVC_ADDR1:  next_st.rdata = st.addr[15:8];
				`NVC_DATA0:  next_st.rdata = st.data[7:0];
				`NVC_DATA1:  next_st.rdata = st.data[15:8];
				`NVC_CMD:    next_st.rdata = {1'b0, st.cmd};
				`NVC_CTRLB:  next_st.rdata = st.ctrlb;
				`NVC_STATUS: next_st.rdata = {busy, st.fail, 4'h0, fbuf.any, ebuf.any};
				default:     next_st.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st <= '{fsm: NVC_IDLE, cmd: `NVC_CMD_RESET, clr: '0, wout: 16'hffff, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs straight from flops
	// ----------------------------------------
	assign reg_rdata_o = st.rdata;
	assign mem_start_o = st.start;
	assign mem_cmd_o   = st.run_cmd;
	assign mem_addr_o  = st.addr;
	assign mem_wdata_o = st.wout;
	assign mem_tag_o   = st.tout;
	assign rd_grant_o  = st.grant;
	assign cpu_stall_o = st.stall;
	assign busy_o      = st.busy_flag;
endmodule // nvc_ctrl

// ### sim/nvc_ctrl_checker.sv
// port checker for the nvm command sequencer
// assumes a bind onto nvc_ctrl and a single clock domain
module nvc_ctrl_checker
	import nvc_pkg::*;
(
	input wire logic       clock_i,     // system clock
	input wire logic       rst_n_i,     // sync reset, active low
	input wire logic       reg_rd_i,    // register read strobe
	input wire logic [7:0] reg_rdata_o, // register read data
	input wire logic       external_i,  // external access
	input wire logic       mem_rd_i,    // memory read trigger
	input wire logic       mem_wr_i,    // memory write trigger
	input wire logic       app_rd_i,    // application section read
	input wire logic       brownout_i,  // supply threshold hit
	input wire logic       mem_done_i,  // array finished
	input wire logic       mem_start_o, // start pulse to array
	input wire logic       rd_grant_o,  // read allowed
	input wire logic       cpu_stall_o, // processor halt
	input wire logic       busy_o       // operation in progress
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside its slot");
	start_pulse_a: assert property (mem_start_o |=> !mem_start_o)
		else $error("start longer than one cycle");
	trig_blocked_a: assert property (busy_o && mem_wr_i |=> !mem_start_o)
		else $error("trigger taken while busy");
	busy_bound_a: assert property ($rose(busy_o) |-> ##[1:24] !busy_o)
		else $error("busy never released");
	done_release_a: assert property (busy_o && mem_done_i && !brownout_i |=> busy_o ##1 !busy_o)
		else $error("busy wrong after done");
	brownout_abort_a: assert property (busy_o && brownout_i |-> ##[1:3] !busy_o)
		else $error("brownout did not abort");
	read_block_a: assert property (busy_o && mem_rd_i && (external_i || app_rd_i) |=> !rd_grant_o)
		else $error("read granted while busy");
	read_grant_a: assert property (!busy_o && mem_rd_i |=> rd_grant_o)
		else $error("idle read not granted");
	stall_start_a: assert property ($rose(cpu_stall_o) |-> $rose(busy_o))
		else $error("stall without operation");

	cover property ($rose(busy_o));
	cover property (busy_o && brownout_i);
	cover property (busy_o && mem_rd_i && app_rd_i);
endmodule // nvc_ctrl_checker

bind nvc_ctrl nvc_ctrl_checker u_chk (.clock_i, .rst_n_i, .reg_rd_i, .reg_rdata_o, .external_i,
	.mem_rd_i, .mem_wr_i, .app_rd_i, .brownout_i, .mem_done_i, .mem_start_o, .rd_grant_o,
	.cpu_stall_o, .busy_o);

// ### sim/nvc_mem_model.sv
// behavioural flash and eeprom array answering the sequencer
// assumes start pulses from nvc_ctrl and a settable answer delay
`include "nvc_regs.svh"
module nvc_mem_model
	import nvc_pkg::*;
(
	input  wire logic        clock_i, // system clock
	input  wire logic        rst_n_i, // sync reset, active low
	input  wire logic        start_i, // start pulse
	input  wire logic [6:0]  cmd_i,   // command
	input  wire logic [15:0] addr_i,  // address
	input  wire logic [15:0] wdata_i, // buffer word
	input  wire logic        tag_i,   // eeprom location tagged
	input  wire logic [7:0]  delay_i, // cycles before done
	output logic             done_o   // finished pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] fm [0:255];
	logic [7:0]  em [0:255];
	logic [7:0]  cnt;
	logic        run;

	// apply the command at start, answer after the delay
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		if (!rst_n_i) begin
			run <= 1'b0;
		end else if (start_i) begin
			run <= 1'b1;
			cnt <= delay_i;
			case (cmd_i)
				`NVC_C_ER_FPG: fm[addr_i[8:1]] <= 16'hffff;
				`NVC_C_WR_FPG, `NVC_C_EW_FPG: fm[addr_i[8:1]] <= wdata_i;
				`NVC_C_ER_EPG: if (tag_i) em[addr_i[7:0]] <= 8'hff;
				`NVC_C_WR_EPG, `NVC_C_EW_EPG: if (tag_i) em[addr_i[7:0]] <= wdata_i[7:0];
				default: ;
			endcase
		end else if (run) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h00) begin
				done_o <= 1'b1;
				run <= 1'b0;
			end
		end
	end
endmodule // nvc_mem_model

// ### sim/test_nvc_ctrl.sv
// self-checking bench for the nvm command sequencer
// assumes the array model and the bound checker beside it
`include "nvc_regs.svh"
module test_nvc_ctrl
	import nvc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        external_i = 1'b1;
	logic        mem_rd_i = 1'b0;
	logic        mem_wr_i = 1'b0;
	logic        app_rd_i = 1'b0;
	logic        brownout_i = 1'b0;
	logic [7:0]  delay_i = 8'h08;
	logic        mem_done_i, mem_start_o, mem_tag_o, rd_grant_o, cpu_stall_o, busy_o;
	logic [7:0]  reg_rdata_o;
	logic [6:0]  mem_cmd_o;
	logic [15:0] mem_addr_o, mem_wdata_o;
	logic [6:0]  acts [3] = '{`NVC_C_ER_FBUF, `NVC_C_ER_EBUF, `NVC_C_CRC};
	int          compares = 0;
	int          miscompares = 0;

	always #50 clock_i = ~clock_i;

	nvc_ctrl uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .external_i(external_i), .mem_rd_i(mem_rd_i),
		.mem_wr_i(mem_wr_i), .app_rd_i(app_rd_i), .brownout_i(brownout_i),
		.mem_done_i(mem_done_i), .mem_start_o(mem_start_o), .mem_cmd_o(mem_cmd_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_tag_o(mem_tag_o),
		.rd_grant_o(rd_grant_o), .cpu_stall_o(cpu_stall_o), .busy_o(busy_o));
	nvc_mem_model u_mem (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(mem_start_o),
		.cmd_i(mem_cmd_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .tag_i(mem_tag_o),
		.delay_i(delay_i), .done_o(mem_done_i));

	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 chk(n, {8'h00, reg_rdata_o}, {8'h00, e});
		@(posedge clock_i);
	endtask
	task automatic cmd_at(input logic [15:0] a, input logic [6:0] c);
		wr(`NVC_ADDR0, a[7:0]);
		wr(`NVC_ADDR1, a[15:8]);
		wr(`NVC_CMD, {1'b0, c});
	endtask
	task automatic trig();
		mem_wr_i <= 1'b1;
		@(posedge clock_i);
		mem_wr_i <= 1'b0;
		@(posedge clock_i);
		#1;
	endtask
	task automatic rdmem(input logic e);
		mem_rd_i <= 1'b1;
		@(posedge clock_i);
		mem_rd_i <= 1'b0;
		#1 chk("grant", {15'h0, rd_grant_o}, {15'h0, e});
	endtask
	task automatic settle();
		repeat (2) @(posedge clock_i);
		#1;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 40 && busy_o !== 1'b0; i++)
			@(posedge clock_i);
		#1 chk("busy", {15'h0, busy_o}, 16'h0000);
	endtask
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		rd(`NVC_STATUS, 8'h00, "status");
		rd(`NVC_CMD, 8'h00, "cmd");
		rd(4'hf, 8'h00, "unmapped");
		chk("fword", mem_wdata_o, 16'hffff);
		// two loads into one word give the and of both
		cmd_at(16'h0002, `NVC_C_LD_FBUF);
		wr(`NVC_DATA0, 8'hf0);
		wr(`NVC_DATA1, 8'h5a);
		trig();
		wr(`NVC_DATA0, 8'h3c);
		wr(`NVC_DATA1, 8'hff);
		trig();
		settle();
		chk("fword", mem_wdata_o, 16'h5a30);
		rd(`NVC_STATUS, 8'h02, "status");
		wr(`NVC_ADDR0, 8'h04);
		settle();
		chk("fword", mem_wdata_o, 16'hffff);
		// page write, blocked accesses meanwhile
		cmd_at(16'h0002, `NVC_C_WR_FPG);
		trig();
		chk("busy", {15'h0, busy_o}, 16'h0001);
		chk("mcmd", {9'h0, mem_cmd_o}, {9'h0, `NVC_C_WR_FPG});
		chk("maddr", mem_addr_o, 16'h0002);
		wr(`NVC_CMD, {1'b0, `NVC_C_ER_FPG});
		app_rd_i <= 1'b1;
		rdmem(1'b0);
		wait_idle();
		rdmem(1'b1);
		app_rd_i <= 1'b0;
		rd(`NVC_CMD, {1'b0, `NVC_C_WR_FPG}, "cmd");
		chk("array", u_mem.fm[1], 16'h5a30);
		settle();
		chk("fword", mem_wdata_o, 16'hffff);
		wr(`NVC_CMD, 8'h00);
		rd(`NVC_CMD, 8'h00, "cmd");
		// eeprom load tags only its location
		cmd_at(16'h0003, `NVC_C_LD_EBUF);
		wr(`NVC_DATA0, 8'h0f);
		trig();
		settle();
		chk("tag", {15'h0, mem_tag_o}, 16'h0001);
		rd(`NVC_STATUS, 8'h01, "status");
		wr(`NVC_ADDR0, 8'h05);
		settle();
		chk("tag", {15'h0, mem_tag_o}, 16'h0000);
		cmd_at(16'h0003, `NVC_C_WR_EPG);
		trig();
		wait_idle();
		settle();
		chk("tag", {15'h0, mem_tag_o}, 16'h0000);
		rd(`NVC_STATUS, 8'h00, "status");
		// every action command starts from the execute bit
		foreach (acts[i]) begin
			wr(`NVC_CMD, {1'b0, acts[i]});
			wr(`NVC_NVM_CONTROL_A, 8'h01);
			#1 chk("busy", {15'h0, busy_o}, {15'h0, acts[i] == `NVC_C_CRC});
			wait_idle();
		end
		// external write to the production row is refused
		wr(`NVC_CMD, {1'b0, `NVC_C_RD_PSIG});
		trig();
		chk("busy", {15'h0, busy_o}, 16'h0000);
		// self-programming trigger needs the unlock key
		external_i <= 1'b0;
		cmd_at(16'h0002, `NVC_C_ER_FPG);
		trig();
		chk("busy", {15'h0, busy_o}, 16'h0000);
		wr(`NVC_PROTECT, `NVC_UNLOCK_KEY);
		trig();
		chk("busy", {15'h0, busy_o}, 16'h0001);
		chk("stall", {15'h0, cpu_stall_o}, 16'h0001);
		wait_idle();
		// brownout aborts a slow erase and flags it
		external_i <= 1'b1;
		delay_i <= 8'h0f;
		wr(`NVC_CMD, {1'b0, `NVC_C_ER_FPG});
		trig();
		brownout_i <= 1'b1;
		settle();
		chk("busy", {15'h0, busy_o}, 16'h0000);
		brownout_i <= 1'b0;
		repeat (20) @(posedge clock_i);
		rd(`NVC_STATUS, 8'h40, "status");
		wr(`NVC_STATUS, 8'h40);
		rd(`NVC_STATUS, 8'h00, "status");
		test_done();
	end

	// watchdog well beyond the expected run
	initial begin
		#500000;
		miscompares++;
		test_done();
	end
endmodule // test_nvc_ctrl
